/* design/pgm_defs.vh */
`ifndef PGM_DEFS_VH
`define PGM_DEFS_VH
// Notes on behaviour
// RULE_01: The data bit 3 pin control field in bits 10:8 resets to 000; 000 is normal data, 001 indicator three, 010 wake-on-LAN.
// RULE_02: Data bit 3 control 011 drives the clock picked by its source field in bits 14:12.
// RULE_03: On every muxed pin control 100 drives the 1588 transmit start-of-frame and 101 the receive one.
// RULE_04: On every muxed pin control 110 forces a constant low and 111 a constant high.
// RULE_05: Indicator pin one control in bits 2:0 resets from a strap; 000 tri-states, 001 indicator one, 010 wake-on-LAN.
// RULE_06: Indicator pin one control 011 drives the clock picked by bits 6:4 of the same register.
// RULE_07: Collision pin control resets to 000; 000 normal collision, 001 multi-function indicator, 010 wake-on-LAN.
// RULE_08: Collision pin clock mode drives the clock picked by its source field in bits 6:4, reset 000.
// RULE_09: Clock source 000 is the MAC interface clock, 001 the crystal input, 010 the internal 25 MHz reference.
// RULE_10: Clock source 100 is the 50 MHz reduced-pin master reference; 011 and 101 are reserved.
// RULE_11: Clock source 110 is the 125 MHz free-running clock and 111 the 125 MHz recovered clock.
// RULE_12: The MAC interface clock runs at 25 MHz in MII, 50 MHz in RMII and 25 MHz in RGMII mode.
// RULE_13: Unused bits of both control registers are read-only zero, bit 15 of the first included.

// Register indices and byte addresses
`define PGM_IDX_CTRL_ONE 16'h0462
`define PGM_IDX_CTRL_TWO 16'h0463
`define PGM_ADDR_CTRL_ONE 18'h01188
`define PGM_ADDR_CTRL_TWO 18'h0118c

// Field positions
`define PGM_D3_CTRL_HI 10
`define PGM_D3_CTRL_LO 8
`define PGM_D3_SRC_HI 14
`define PGM_D3_SRC_LO 12
`define PGM_LOW_CTRL_HI 2
`define PGM_LOW_CTRL_LO 0
`define PGM_LOW_SRC_HI 6
`define PGM_LOW_SRC_LO 4

// Reset values
`define PGM_RST_FIELD 3'h0

// Pin control codes
`define PGM_FN_NORMAL 3'h0
`define PGM_FN_IND 3'h1
`define PGM_FN_WAKE 3'h2
`define PGM_FN_CLK 3'h3
`define PGM_FN_TX_SOF 3'h4
`define PGM_FN_RX_SOF 3'h5
`define PGM_FN_ZERO 3'h6
`define PGM_FN_ONE 3'h7

// Clock source codes
`define PGM_CS_MAC 3'h0
`define PGM_CS_XTAL 3'h1
`define PGM_CS_REF25 3'h2
`define PGM_CS_REF50 3'h4
`define PGM_CS_FREE125 3'h6
`define PGM_CS_REC125 3'h7

// MAC interface modes
`define PGM_MODE_MII 2'h0
`define PGM_MODE_RMII 2'h1
`define PGM_MODE_RGMII 2'h2
`endif

/* design/pgm_pin_mux.v */
`timescale 1ns/1ps
`include "pgm_defs.vh"
module pgm_pin_mux (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [2:0] indicator_pin_one_strap,
    input wire [1:0] mac_if_mode,
    input wire clk_mac25,
    input wire clk_mac50,
    input wire crystal_input_pin,
    input wire clk_ref25,
    input wire clk_free125,
    input wire clk_rec125,
    input wire rx_data_bit3,
    input wire collision,
    input wire indicator_output_one,
    input wire indicator_output_three,
    input wire multi_function_indicator,
    input wire wake_on_lan_indication,
    input wire tx_sof_indication,
    input wire rx_sof_indication,
    output wire receive_data_bit3_pin_o,
    output wire receive_data_bit3_pin_oe,
    output wire indicator_pin_one_o,
    output wire indicator_pin_one_oe,
    output wire collision_pin_o,
    output wire collision_pin_oe
);

// ----------------------------------------------------------------
// Register state
// ----------------------------------------------------------------
reg [2:0] d3_ctrl;
reg [2:0] d3_src;
reg [2:0] ind1_ctrl;
reg [2:0] ind1_src;
reg [2:0] col_ctrl;
reg [2:0] col_src;
reg strap_pending;
reg [31:0] next_prdata;
reg mac_clk;

wire wr_en;
wire rd_setup;
wire hit_one;
wire hit_two;
wire [15:0] reg_one;
wire [15:0] reg_two;

assign hit_one = (paddr == `PGM_ADDR_CTRL_ONE);
assign hit_two = (paddr == `PGM_ADDR_CTRL_TWO);
assign wr_en = psel & penable & pwrite;
assign rd_setup = psel & ~pwrite; // Read request, read data captured from the setup cycle on
assign pready = 1'b1;
assign pslverr = psel & penable & ~(hit_one | hit_two); // Unmapped address

// Readback, unused bits wired to zero
assign reg_one = {1'b0, d3_src, 1'b0, d3_ctrl, 1'b0, ind1_src, 1'b0, ind1_ctrl}; // see RULE_13
assign reg_two = {9'h000, col_src, 1'b0, col_ctrl}; // see RULE_13

// ----------------------------------------------------------------
// Register writes and strap capture
// ----------------------------------------------------------------
// Register one, indicator pin one fields; a write on the strap edge wins over the strap
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ind1_ctrl <= `PGM_RST_FIELD;
        ind1_src <= `PGM_RST_FIELD;
        strap_pending <= 1'b1;
    end
    else
    begin
        strap_pending <= 1'b0;
        if (strap_pending)
        begin
            ind1_ctrl <= indicator_pin_one_strap; // see RULE_05
        end
        if (wr_en && hit_one)
        begin
            ind1_src <= pwdata[`PGM_LOW_SRC_HI:`PGM_LOW_SRC_LO];
            ind1_ctrl <= pwdata[`PGM_LOW_CTRL_HI:`PGM_LOW_CTRL_LO];
        end
    end
end

// Register one, data bit 3 pin fields
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        d3_ctrl <= `PGM_RST_FIELD; // see RULE_01
        d3_src <= `PGM_RST_FIELD;
    end
    else if (wr_en && hit_one)
    begin
        d3_src <= pwdata[`PGM_D3_SRC_HI:`PGM_D3_SRC_LO];
        d3_ctrl <= pwdata[`PGM_D3_CTRL_HI:`PGM_D3_CTRL_LO];
    end
end

// Register two, collision pin fields
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        col_ctrl <= `PGM_RST_FIELD; // see RULE_07
        col_src <= `PGM_RST_FIELD; // see RULE_08
    end
    else if (wr_en && hit_two)
    begin
        col_src <= pwdata[`PGM_LOW_SRC_HI:`PGM_LOW_SRC_LO];
        col_ctrl <= pwdata[`PGM_LOW_CTRL_HI:`PGM_LOW_CTRL_LO];
    end
end

// Read data select
always @*
begin
    next_prdata = 32'h00000000;
    if (rd_setup && hit_one)
    begin
        next_prdata = {16'h0000, reg_one};
    end
    else if (rd_setup && hit_two)
    begin
        next_prdata = {16'h0000, reg_two};
    end
end

// Read data register, valid in the access phase
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h00000000;
    end
    else
    begin
        prdata <= next_prdata;
    end
end

// ----------------------------------------------------------------
// Clock and function selection
// ----------------------------------------------------------------
// MAC interface clock follows the interface mode
always @*
begin
    case (mac_if_mode)
        `PGM_MODE_RMII: mac_clk = clk_mac50; // see RULE_12
        `PGM_MODE_MII: mac_clk = clk_mac25; // see RULE_12
        `PGM_MODE_RGMII: mac_clk = clk_mac25; // see RULE_12
        default: mac_clk = clk_mac25;
    endcase
end

// ----------------------------------------------------------------
// Pin slices, every source a port so each pin follows its sources
// ----------------------------------------------------------------
// Receive data bit 3 pin: always driven, normal level is receive data
pgm_pin_slice #(
    .IDLE_RELEASE(0)
) u_d3_slice (
    .ctrl(d3_ctrl), // see RULE_01
    .src(d3_src), // see RULE_02
    .normal_level(rx_data_bit3),
    .indicator_level(indicator_output_three),
    .wake_level(wake_on_lan_indication),
    .tx_sof_level(tx_sof_indication),
    .rx_sof_level(rx_sof_indication),
    .mac_clk(mac_clk),
    .xtal_clk(crystal_input_pin),
    .ref25_clk(clk_ref25),
    .ref50_clk(clk_mac50), // Reduced-pin master reference, see RULE_10
    .free125_clk(clk_free125),
    .rec125_clk(clk_rec125),
    .pin_o(receive_data_bit3_pin_o),
    .pin_oe(receive_data_bit3_pin_oe)
);

// Indicator pin one: released on code 000, so its normal level is unused
pgm_pin_slice #(
    .IDLE_RELEASE(1)
) u_ind1_slice (
    .ctrl(ind1_ctrl), // see RULE_05
    .src(ind1_src), // see RULE_06
    .normal_level(1'b0),
    .indicator_level(indicator_output_one),
    .wake_level(wake_on_lan_indication),
    .tx_sof_level(tx_sof_indication),
    .rx_sof_level(rx_sof_indication),
    .mac_clk(mac_clk),
    .xtal_clk(crystal_input_pin),
    .ref25_clk(clk_ref25),
    .ref50_clk(clk_mac50), // see RULE_10
    .free125_clk(clk_free125),
    .rec125_clk(clk_rec125),
    .pin_o(indicator_pin_one_o),
    .pin_oe(indicator_pin_one_oe) // see RULE_05
);

// Collision pin: always driven, normal level is collision
pgm_pin_slice #(
    .IDLE_RELEASE(0)
) u_col_slice (
    .ctrl(col_ctrl), // see RULE_07
    .src(col_src), // see RULE_08
    .normal_level(collision),
    .indicator_level(multi_function_indicator),
    .wake_level(wake_on_lan_indication),
    .tx_sof_level(tx_sof_indication),
    .rx_sof_level(rx_sof_indication),
    .mac_clk(mac_clk),
    .xtal_clk(crystal_input_pin),
    .ref25_clk(clk_ref25),
    .ref50_clk(clk_mac50), // see RULE_10
    .free125_clk(clk_free125),
    .rec125_clk(clk_rec125),
    .pin_o(collision_pin_o),
    .pin_oe(collision_pin_oe)
);

endmodule // pgm_pin_mux

// ----------------------------------------------------------------
// One multiplexed pin: clock source pick, function pick, drive enable
// ----------------------------------------------------------------
module pgm_pin_slice #(
    // Set where code 000 releases the pin instead of driving it
    parameter IDLE_RELEASE = 0
) (
    input wire [2:0] ctrl,
    input wire [2:0] src,
    input wire normal_level,
    input wire indicator_level,
    input wire wake_level,
    input wire tx_sof_level,
    input wire rx_sof_level,
    input wire mac_clk,
    input wire xtal_clk,
    input wire ref25_clk,
    input wire ref50_clk,
    input wire free125_clk,
    input wire rec125_clk,
    output reg pin_o,
    output reg pin_oe
);

// Selected clock source level
reg src_clk;

// ----------------------------------------------------------------
// Clock source
// ----------------------------------------------------------------
// Clock source pick; reserved codes give a quiet low
always @*
begin
    case (src)
        `PGM_CS_MAC: src_clk = mac_clk; // see RULE_09
        `PGM_CS_XTAL: src_clk = xtal_clk; // see RULE_09
        `PGM_CS_REF25: src_clk = ref25_clk; // see RULE_09
        `PGM_CS_REF50: src_clk = ref50_clk; // see RULE_10
        `PGM_CS_FREE125: src_clk = free125_clk; // see RULE_11
        `PGM_CS_REC125: src_clk = rec125_clk; // see RULE_11
        default: src_clk = 1'b0; // see RULE_10
    endcase
end

// ----------------------------------------------------------------
// Pin function
// ----------------------------------------------------------------
// Function pick by control code
always @*
begin
    case (ctrl)
        `PGM_FN_NORMAL: pin_o = normal_level;
        `PGM_FN_IND: pin_o = indicator_level;
        `PGM_FN_WAKE: pin_o = wake_level;
        `PGM_FN_CLK: pin_o = src_clk;
        `PGM_FN_TX_SOF: pin_o = tx_sof_level; // see RULE_03
        `PGM_FN_RX_SOF: pin_o = rx_sof_level; // see RULE_03
        `PGM_FN_ZERO: pin_o = 1'b0; // see RULE_04
        default: pin_o = 1'b1; // see RULE_04
    endcase
end

// Drive enable; only a releasing pin lets go on code 000
always @*
begin
    if (IDLE_RELEASE != 0 && ctrl == `PGM_FN_NORMAL)
    begin
        pin_oe = 1'b0;
    end
    else
    begin
        pin_oe = 1'b1;
    end
end

endmodule // pgm_pin_slice

/* testbench/pgm_pin_mux_assertions.sv */
`timescale 1ns/1ps
`include "pgm_defs.vh"
module pgm_pin_mux_assertions (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire tx_sof_indication,
    input wire rx_sof_indication,
    input wire wake_on_lan_indication,
    input wire receive_data_bit3_pin_o,
    input wire indicator_pin_one_oe,
    input wire collision_pin_o
);
    // ----
    // Completed writes to each register
    // ----
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_w1;
        psel && penable && pwrite && paddr == `PGM_ADDR_CTRL_ONE;
    endsequence
    sequence s_w2;
        psel && penable && pwrite && paddr == `PGM_ADDR_CTRL_TWO;
    endsequence
    a_d3_low: assert property (s_w1 ##0 pwdata[10:8] == 3'h6 |=> !receive_data_bit3_pin_o)
        else $error("Data pin not low");
    a_d3_high: assert property (s_w1 ##0 pwdata[10:8] == 3'h7 |=> receive_data_bit3_pin_o)
        else $error("Data pin not high");
    a_d3_txsof: assert property (s_w1 ##0 pwdata[10:8] == 3'h4 |=> receive_data_bit3_pin_o == tx_sof_indication)
        else $error("Data pin not tx sof");
    a_ind_tristate: assert property (s_w1 ##0 pwdata[2:0] == 3'h0 |=> !indicator_pin_one_oe)
        else $error("Indicator pin driven");
    a_ind_drive: assert property (s_w1 ##0 pwdata[2:0] != 3'h0 |=> indicator_pin_one_oe)
        else $error("Indicator pin not driven");
    a_col_wol: assert property (s_w2 ##0 pwdata[2:0] == 3'h2 |=> collision_pin_o == wake_on_lan_indication)
        else $error("Collision pin not wake");
    a_col_rxsof: assert property (s_w2 ##0 pwdata[2:0] == 3'h5 |=> collision_pin_o == rx_sof_indication)
        else $error("Collision pin not rx sof");
    a_unused_zero: assert property (psel && penable && !pwrite |-> prdata[31:15] == 17'h0 && !prdata[3])
        else $error("Unused bits not zero");
endmodule // pgm_pin_mux_assertions
bind pgm_pin_mux pgm_pin_mux_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .tx_sof_indication, .rx_sof_indication, .wake_on_lan_indication, .receive_data_bit3_pin_o,
    .indicator_pin_one_oe, .collision_pin_o);

/* testbench/pgm_pin_sampler.sv */
`timescale 1ns/1ps
module pgm_pin_sampler (
    input wire pclk,
    input wire [2:0] po,
    input wire [2:0] poe,
    output wire [2:0] lvl
);
    reg [2:0] last = 3'h0;
    // Last driven level is kept; a released pin shows its inverse
    assign lvl = (po & poe) | (~last & ~poe);
    always @(posedge pclk)
        last <= (po & poe) | (last & ~poe);
endmodule // pgm_pin_sampler

/* testbench/phy_gpio_pin_function_mux_bench.sv */
`timescale 1ns/1ps
`include "pgm_defs.vh"
module phy_gpio_pin_function_mux_bench;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err = 0;
    reg [17:0] paddr = 0;
    reg [31:0] pwdata = 0, d = 0, q = 0, r = 0;
    reg [2:0] strap = 0, c = 0, s = 0;
    reg [1:0] mode = 0, p = 0;
    reg [15:0] sv = 0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [2:0] po, poe, lvl;
    integer n_fail = 0, tests_run = 0, seed = 32'h486c5326, k, j, t;
    always #10 pclk = ~pclk;
    pgm_pin_mux u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .indicator_pin_one_strap(strap), .mac_if_mode(mode), .clk_mac25(sv[0]), .clk_mac50(sv[1]),
        .crystal_input_pin(sv[2]), .clk_ref25(sv[3]), .clk_free125(sv[4]), .clk_rec125(sv[5]),
        .rx_data_bit3(sv[6]), .collision(sv[7]), .indicator_output_three(sv[8]), .indicator_output_one(sv[9]),
        .multi_function_indicator(sv[10]), .wake_on_lan_indication(sv[11]), .tx_sof_indication(sv[12]),
        .rx_sof_indication(sv[13]), .receive_data_bit3_pin_o(po[0]), .receive_data_bit3_pin_oe(poe[0]),
        .indicator_pin_one_o(po[1]), .indicator_pin_one_oe(poe[1]), .collision_pin_o(po[2]),
        .collision_pin_oe(poe[2]));
    pgm_pin_sampler u_pin (.pclk, .po, .poe, .lvl);
    // Chosen clock source level
    function ck(input [2:0] cs);
        case (cs)
            3'h0: ck = (mode == 2'h1) ? sv[1] : sv[0];
            3'h1: ck = sv[2];
            3'h2: ck = sv[3];
            3'h4: ck = sv[1];
            3'h6: ck = sv[4];
            3'h7: ck = sv[5];
            default: ck = 1'b0;
        endcase
    endfunction
    // Expected pin level for a pin, control and source
    function px(input [1:0] pn, input [2:0] cc, input [2:0] cs);
        case (cc)
            3'h0: px = (pn == 0) ? sv[6] : (pn == 1) ? 1'b0 : sv[7];
            3'h1: px = sv[8 + pn];
            3'h2: px = sv[11];
            3'h3: px = ck(cs);
            3'h7: px = 1'b1;
            default: px = (cc == 3'h4) ? sv[12] : (cc == 3'h5) ? sv[13] : 1'b0;
        endcase
    endfunction
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input reg [31:0] seen, input reg [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // One APB transfer, answer taken at the edge with pready high
    task apb(input reg w, input reg [17:0] a, input reg [31:0] v);
        begin
            @(posedge pclk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= v;
            @(posedge pclk);
            penable <= 1;
            for (t = 0; t < 20; t = t + 1)
            begin
                @(posedge pclk);
                q = prdata;
                err = pslverr;
                if (pready === 1'b1)
                    t = 99;
            end
            psel <= 0;
            penable <= 0;
            if (t < 100)
            begin
                $display("[FAIL] %0t bus timeout", $time);
                n_fail = n_fail + 1;
                end_of_test;
            end
        end
    endtask
    initial
    begin
        r = $random(seed);
        strap = r[2:0];
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, `PGM_ADDR_CTRL_ONE, 0);
        chk(q, {29'h0, strap});
        chk(err, 0);
        apb(0, `PGM_ADDR_CTRL_TWO, 0);
        chk(q, 0);
        $display("reset test done");
        for (k = 0; k < 64; k = k + 1)
        begin
            c = k[5:3];
            s = k[2:0];
            d = $random(seed);
            d[14:12] = s;
            d[10:8] = c;
            d[6:4] = s;
            d[2:0] = c;
            apb(1, `PGM_ADDR_CTRL_ONE, d);
            apb(1, `PGM_ADDR_CTRL_TWO, d);
            apb(0, `PGM_ADDR_CTRL_ONE, 0);
            chk(q, d & 32'h7777);
            apb(0, `PGM_ADDR_CTRL_TWO, 0);
            chk(q, d & 32'h77);
            repeat (3)
            begin
                @(posedge pclk);
                r = $random(seed);
                sv <= r[15:0];
                mode <= r[17:16];
                #1;
                for (j = 0; j < 3; j = j + 1)
                begin
                    p = j;
                    chk({poe[p], poe[p] & lvl[p]}, {p != 1 || c != 0, px(p, c, s)});
                end
            end
        end
        $display("mux test done");
        // Reset in mid-run with every field set, and a fresh strap
        @(posedge pclk);
        presetn <= 0;
        r = $random(seed);
        strap <= r[2:0];
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, `PGM_ADDR_CTRL_ONE, 0);
        chk(q, {29'h0, strap});
        apb(0, `PGM_ADDR_CTRL_TWO, 0);
        chk(q, 0);
        $display("mid-run reset test done");
        apb(1, 18'h01190, 32'hffffffff);
        apb(0, 18'h01190, 0);
        chk(q, 0);
        chk(err, 1);
        apb(0, `PGM_ADDR_CTRL_ONE, 0);
        chk(q, {29'h0, strap});
        apb(0, `PGM_ADDR_CTRL_TWO, 0);
        chk(q, 0);
        $display("unmapped test done");
        end_of_test;
    end
endmodule // phy_gpio_pin_function_mux_bench
